/* File: inc/bsf_pkg.sv */
// bit, shift and flag unit: shared constants, types and operation codes
// Summary of operation
// - rotate left through carry, one cycle, flags
// - rotate right through carry, half-carry kept
// - io bit forced one, two cycles, flags kept
// - io bit forced zero, two cycles, flags kept
// - register bit copied into transfer flag
// - transfer flag copied into register bit
// - overflow flag raise and lower, one cycle
// - half-carry flag raise and lower, one cycle
// - signed-test flag raise and lower, one cycle
// - break hands control to debug, one cycle
// - sleep requests power-down state, one cycle
// - watchdog restart pulse, one cycle, flags kept
// - low 64 io bytes cost one cycle more
// - nonvolatile access adds one or more cycles
package bsf_pkg;

  // ****************************************
  // widths and field positions
  // ****************************************
  localparam int          DATA_W      = 8;
  localparam int          CNT_W       = 4;
  localparam logic [2:0]  FLAG_C      = 3'h0;
  localparam logic [2:0]  FLAG_Z      = 3'h1;
  localparam logic [2:0]  FLAG_N      = 3'h2;
  localparam logic [2:0]  FLAG_V      = 3'h3;
  localparam logic [2:0]  FLAG_S      = 3'h4;
  localparam logic [2:0]  FLAG_H      = 3'h5;
  localparam logic [2:0]  FLAG_T      = 3'h6;
  localparam logic [2:0]  FLAG_I      = 3'h7;
  localparam logic [7:0]  STATUS_FLAGS_REGISTER_RESET  = 8'h00;
  localparam logic [7:0]  IO_LOW_LIMIT = 8'h40;
  localparam logic [3:0]  BASE_MIN    = 4'h1;

  // ****************************************
  // software register offsets
  // ****************************************
  localparam logic [1:0]  REG_STATUS  = 2'h0;
  localparam logic [1:0]  REG_RESULT  = 2'h1;
  localparam logic [1:0]  REG_STATE   = 2'h2;

  // ****************************************
  // operations
  // ****************************************
  typedef enum logic [5:0] {
    OP_NOP, OP_LOGICAL_SHIFT_UP, OP_LOGICAL_SHIFT_DOWN, OP_ROTATE_LEFT_VIA_CARRY,
    OP_ROTATE_RIGHT_VIA_CARRY, OP_ARITHMETIC_SHIFT_DOWN, OP_NIBBLE_EXCHANGE,
    OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO, OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT, OP_GENERIC_FLAG_RAISE, OP_GENERIC_FLAG_LOWER,
    OP_CARRY_RAISE, OP_CARRY_LOWER, OP_NEGATIVE_RAISE, OP_NEGATIVE_LOWER,
    OP_ZERO_RAISE, OP_ZERO_LOWER, OP_IRQ_ENABLE_RAISE, OP_IRQ_ENABLE_LOWER,
    OP_SIGNED_TEST_RAISE, OP_SIGNED_TEST_LOWER, OP_OVERFLOW_FLAG_RAISE,
    OP_OVERFLOW_FLAG_LOWER, OP_TRANSFER_FLAG_RAISE, OP_TRANSFER_FLAG_LOWER,
    OP_HALF_CARRY_RAISE, OP_HALF_CARRY_LOWER, OP_DEBUG_BREAK, OP_SLEEP_ENTER,
    OP_WATCHDOG_RESTART_INSTR, OP_DATA_ACCESS
  } bsf_op_t;

  typedef enum logic [1:0] {SPACE_RAM, SPACE_IO, SPACE_NVM} bsf_space_t;

  typedef struct packed {
    bsf_op_t            op;
    logic [DATA_W-1:0]  operand;
    logic [2:0]         bit_sel;
    logic [7:0]         io_addr;
    bsf_space_t         space;
    logic [CNT_W-1:0]   base_cycles;
  } bsf_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic [DATA_W-1:0]  status_flags_register;
  } bsf_res_t;

endpackage : bsf_pkg

/* File: rtl/bsf_bit_put.sv */
// single bit insertion into a word
`timescale 1ns/100ps
module bsf_bit_put #(
  parameter int W  = 8,
  parameter int IW = 3
) (
  // word in
  input  wire logic [W-1:0]  data_in,
  input  wire logic [IW-1:0] idx,
  input  wire logic          val,
  // word out
  output wire logic [W-1:0]  data_out
);

  // ****************************************
  // mask and insert
  // ****************************************
  wire logic [W-1:0] mask;

  // one-hot mask at the chosen position
  assign mask     = {{(W-1){1'b0}}, 1'b1} << idx;
  assign data_out = val ? (data_in | mask) : (data_in & ~mask);

endmodule : bsf_bit_put

/* File: rtl/bsf_shifter.sv */
// shift, rotate and nibble exchange; flag results for shift and rotate only
`timescale 1ns/100ps
module bsf_shifter (
  // operation
  input  wire bsf_pkg::bsf_op_t op,
  input  wire logic [7:0]       opnd,
  input  wire logic [7:0]       status_flags_register_in,
  // results
  output logic [7:0]            res,
  output logic [7:0]            status_flags_register_out
);

  // ****************************************
  // datapath
  // ****************************************
  logic c;
  logic h;
  logic n;
  logic v;
  logic upd;

  // result and carry/half-carry per operation
  always_comb
  begin
    res = opnd;
    c   = status_flags_register_in[bsf_pkg::FLAG_C];
    h   = status_flags_register_in[bsf_pkg::FLAG_H];
    upd = 1'b1;
    case (op)
      bsf_pkg::OP_LOGICAL_SHIFT_UP:
      begin
        res = {opnd[6:0], 1'b0};
        c   = opnd[7];
        h   = opnd[3];
      end
      bsf_pkg::OP_ROTATE_LEFT_VIA_CARRY:
      begin
        res = {opnd[6:0], status_flags_register_in[bsf_pkg::FLAG_C]};
        c   = opnd[7];
        h   = opnd[3];
      end
      bsf_pkg::OP_LOGICAL_SHIFT_DOWN:
      begin
        res = {1'b0, opnd[7:1]};
        c   = opnd[0];
      end
      bsf_pkg::OP_ROTATE_RIGHT_VIA_CARRY:
      begin
        res = {status_flags_register_in[bsf_pkg::FLAG_C], opnd[7:1]};
        c   = opnd[0];
      end
      bsf_pkg::OP_ARITHMETIC_SHIFT_DOWN:
      begin
        res = {opnd[7], opnd[7:1]};
        c   = opnd[0];
      end
      bsf_pkg::OP_NIBBLE_EXCHANGE:
      begin
        res = {opnd[3:0], opnd[7:4]};
        upd = 1'b0;
      end
      default:
      begin
        upd = 1'b0;
      end
    endcase
    n        = res[7];
    v        = n ^ c;
    status_flags_register_out = status_flags_register_in;
    if (upd)
    begin
      status_flags_register_out[bsf_pkg::FLAG_C] = c;
      status_flags_register_out[bsf_pkg::FLAG_Z] = (res == 8'h00);
      status_flags_register_out[bsf_pkg::FLAG_N] = n;
      status_flags_register_out[bsf_pkg::FLAG_V] = v;
      status_flags_register_out[bsf_pkg::FLAG_S] = n ^ v;
      status_flags_register_out[bsf_pkg::FLAG_H] = h;
    end
  end

endmodule : bsf_shifter

/* File: rtl/bsf_unit.sv */
// bit, shift and flag execution unit with status flags and access timing
`timescale 1ns/100ps
module bsf_unit (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // instruction issue
  input  wire logic                cmd_valid,
  input  wire bsf_pkg::bsf_cmd_t   cmd,
  output wire logic                cmd_ready,
  // instruction retire
  output logic                     res_valid,
  output bsf_pkg::bsf_res_t        res,
  // io space access
  output wire logic [7:0]          io_addr,
  output wire logic                io_re,
  output wire logic                io_we,
  output wire logic [7:0]          io_wdata,
  input  wire logic [7:0]          io_rdata,
  // nonvolatile memory controller
  input  wire logic                nvm_ready,
  // core control pulses
  output logic                     debug_break,
  output logic                     sleep_req,
  output logic                     wdt_restart,
  // software port
  input  wire logic [1:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_we,
  input  wire logic                reg_re,
  output logic [7:0]               reg_rdata
);

  // ****************************************
  // state and registers
  // ****************************************
  typedef enum {ST_IDLE, ST_IO_RMW, ST_WAIT_CNT, ST_WAIT_NVM} bsf_state_t;

  bsf_state_t                   state_q;
  logic [7:0]                   status_flags_register_q;
  logic [7:0]                   status_flags_register_d;
  logic [7:0]                   io_addr_q;
  logic [2:0]                   io_bit_q;
  logic                         io_one_q;
  logic [bsf_pkg::CNT_W-1:0]    cnt_q;
  logic                         nvm_q;
  logic [7:0]                   rdata_d;
  logic [7:0]                   hold_q;

  // ****************************************
  // decode
  // ****************************************
  wire logic                    acc;
  wire logic                    is_io_op;
  wire logic                    is_dacc;
  wire logic                    is_shift;
  wire logic                    single_acc;
  wire logic                    low_io;
  wire logic [bsf_pkg::CNT_W-1:0] base;
  wire logic [bsf_pkg::CNT_W-1:0] rem;
  wire logic                    dacc_now;
  logic                         flag_hit;
  logic [2:0]                   flag_idx;
  logic                         flag_val;

  // issue handshake and operation classes
  assign cmd_ready  = (state_q == ST_IDLE);
  assign acc        = cmd_valid & cmd_ready;
  assign is_io_op   = (cmd.op == bsf_pkg::OP_IO_BIT_FORCE_ONE) |
                      (cmd.op == bsf_pkg::OP_IO_BIT_FORCE_ZERO);
  assign is_dacc    = (cmd.op == bsf_pkg::OP_DATA_ACCESS);
  assign is_shift   = (cmd.op == bsf_pkg::OP_LOGICAL_SHIFT_UP) |
                      (cmd.op == bsf_pkg::OP_LOGICAL_SHIFT_DOWN) |
                      (cmd.op == bsf_pkg::OP_ROTATE_LEFT_VIA_CARRY) |
                      (cmd.op == bsf_pkg::OP_ROTATE_RIGHT_VIA_CARRY) |
                      (cmd.op == bsf_pkg::OP_ARITHMETIC_SHIFT_DOWN) |
                      (cmd.op == bsf_pkg::OP_NIBBLE_EXCHANGE);
  assign single_acc = acc & ~is_io_op & ~is_dacc;

  // data access cost: base, one more for low io, nvm wait after
  assign low_io   = (cmd.space == bsf_pkg::SPACE_IO) && (cmd.io_addr < bsf_pkg::IO_LOW_LIMIT);
  assign base     = (cmd.base_cycles < bsf_pkg::BASE_MIN) ? bsf_pkg::BASE_MIN : cmd.base_cycles;
  assign rem      = base - bsf_pkg::BASE_MIN + {{(bsf_pkg::CNT_W-1){1'b0}}, low_io};
  assign dacc_now = (rem == '0) && (cmd.space != bsf_pkg::SPACE_NVM);

  // flag instructions: which status bit and which value
  always_comb
  begin
    flag_hit = 1'b1;
    flag_idx = cmd.bit_sel;
    flag_val = 1'b1;
    case (cmd.op)
      bsf_pkg::OP_GENERIC_FLAG_RAISE:     flag_val = 1'b1;
      bsf_pkg::OP_GENERIC_FLAG_LOWER:     flag_val = 1'b0;
      bsf_pkg::OP_CARRY_RAISE:            flag_idx = bsf_pkg::FLAG_C;
      bsf_pkg::OP_NEGATIVE_RAISE:         flag_idx = bsf_pkg::FLAG_N;
      bsf_pkg::OP_ZERO_RAISE:             flag_idx = bsf_pkg::FLAG_Z;
      bsf_pkg::OP_IRQ_ENABLE_RAISE:       flag_idx = bsf_pkg::FLAG_I;
      bsf_pkg::OP_SIGNED_TEST_RAISE:      flag_idx = bsf_pkg::FLAG_S;
      bsf_pkg::OP_OVERFLOW_FLAG_RAISE:    flag_idx = bsf_pkg::FLAG_V;
      bsf_pkg::OP_TRANSFER_FLAG_RAISE:    flag_idx = bsf_pkg::FLAG_T;
      bsf_pkg::OP_HALF_CARRY_RAISE:       flag_idx = bsf_pkg::FLAG_H;
      bsf_pkg::OP_CARRY_LOWER:
      begin
        flag_idx = bsf_pkg::FLAG_C;
        flag_val = 1'b0;
      end
      bsf_pkg::OP_NEGATIVE_LOWER:
      begin
        flag_idx = bsf_pkg::FLAG_N;
        flag_val = 1'b0;
      end
      bsf_pkg::OP_ZERO_LOWER:
      begin
        flag_idx = bsf_pkg::FLAG_Z;
        flag_val = 1'b0;
      end
      bsf_pkg::OP_IRQ_ENABLE_LOWER:
      begin
        flag_idx = bsf_pkg::FLAG_I;
        flag_val = 1'b0;
      end
      bsf_pkg::OP_SIGNED_TEST_LOWER:
      begin
        flag_idx = bsf_pkg::FLAG_S;
        flag_val = 1'b0;
      end
      bsf_pkg::OP_OVERFLOW_FLAG_LOWER:
      begin
        flag_idx = bsf_pkg::FLAG_V;
        flag_val = 1'b0;
      end
      bsf_pkg::OP_TRANSFER_FLAG_LOWER:
      begin
        flag_idx = bsf_pkg::FLAG_T;
        flag_val = 1'b0;
      end
      bsf_pkg::OP_HALF_CARRY_LOWER:
      begin
        flag_idx = bsf_pkg::FLAG_H;
        flag_val = 1'b0;
      end
      bsf_pkg::OP_BIT_TO_TRANSFER_FLAG:
      begin
        flag_idx = bsf_pkg::FLAG_T;
        flag_val = cmd.operand[cmd.bit_sel];
      end
      default:                            flag_hit = 1'b0;
    endcase
  end

  // ****************************************
  // datapath instances
  // ****************************************
  wire logic [7:0] shft_res;
  wire logic [7:0] shft_status_flags_register;
  wire logic [7:0] flag_status_flags_register;
  wire logic [7:0] bld_res;
  wire logic [7:0] io_mod;
  wire logic [7:0] single_status_flags_register;
  wire logic [7:0] single_data;

  bsf_shifter u_shift (
    .op       (cmd.op),
    .opnd     (cmd.operand),
    .status_flags_register_in  (status_flags_register_q),
    .res      (shft_res),
    .status_flags_register_out (shft_status_flags_register)
  );

  // status flag insertion
  bsf_bit_put #(.W(8), .IW(3)) u_flag (
    .data_in  (status_flags_register_q),
    .idx      (flag_idx),
    .val      (flag_val),
    .data_out (flag_status_flags_register)
  );

  // transfer flag into register bit
  bsf_bit_put #(.W(8), .IW(3)) u_bld (
    .data_in  (cmd.operand),
    .idx      (cmd.bit_sel),
    .val      (status_flags_register_q[bsf_pkg::FLAG_T]),
    .data_out (bld_res)
  );

  // io read-modify-write
  bsf_bit_put #(.W(8), .IW(3)) u_io (
    .data_in  (io_rdata),
    .idx      (io_bit_q),
    .val      (io_one_q),
    .data_out (io_mod)
  );

  // retire values of one-cycle instructions
  assign single_status_flags_register = is_shift ? shft_status_flags_register : (flag_hit ? flag_status_flags_register : status_flags_register_q);
  assign single_data = is_shift ? shft_res :
                       ((cmd.op == bsf_pkg::OP_TRANSFER_FLAG_TO_BIT) ? bld_res : cmd.operand);

  // io strobes: read at issue, write back in the next cycle
  assign io_re    = acc & is_io_op;
  assign io_addr  = cmd_ready ? cmd.io_addr : io_addr_q;
  assign io_we    = (state_q == ST_IO_RMW);
  assign io_wdata = io_mod;

  // one-cycle instruction retire wins over a software write of the same cycle
  assign status_flags_register_d = single_acc ? single_status_flags_register :
                  ((reg_we && reg_addr == bsf_pkg::REG_STATUS) ? reg_wdata : status_flags_register_q);

  // software read mux
  always_comb
  begin
    case (reg_addr)
      bsf_pkg::REG_STATUS: rdata_d = status_flags_register_q;
      bsf_pkg::REG_RESULT: rdata_d = res.data;
      bsf_pkg::REG_STATE:  rdata_d = {6'h00, state_q == ST_WAIT_NVM, ~cmd_ready};
      default:             rdata_d = 8'h00;
    endcase
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q     <= ST_IDLE;
      status_flags_register_q      <= bsf_pkg::STATUS_FLAGS_REGISTER_RESET;
      io_addr_q   <= 8'h00;
      io_bit_q    <= 3'h0;
      io_one_q    <= 1'b0;
      cnt_q       <= '0;
      nvm_q       <= 1'b0;
      hold_q      <= 8'h00;
      res_valid   <= 1'b0;
      res         <= '0;
      debug_break <= 1'b0;
      sleep_req   <= 1'b0;
      wdt_restart <= 1'b0;
      reg_rdata   <= 8'h00;
    end
    else
    begin
      status_flags_register_q      <= status_flags_register_d;
      reg_rdata   <= reg_re ? rdata_d : 8'h00;
      res_valid   <= 1'b0;
      debug_break <= acc && cmd.op == bsf_pkg::OP_DEBUG_BREAK;
      sleep_req   <= acc && cmd.op == bsf_pkg::OP_SLEEP_ENTER;
      wdt_restart <= acc && cmd.op == bsf_pkg::OP_WATCHDOG_RESTART_INSTR;
      case (state_q)
        ST_IDLE:
        begin
          if (single_acc)
          begin
            res_valid <= 1'b1;
            res       <= '{data: single_data, status_flags_register: single_status_flags_register};
          end
          else if (acc && is_io_op)
          begin
            io_addr_q <= cmd.io_addr;
            io_bit_q  <= cmd.bit_sel;
            io_one_q  <= (cmd.op == bsf_pkg::OP_IO_BIT_FORCE_ONE);
            state_q   <= ST_IO_RMW;
          end
          else if (acc)
          begin
            nvm_q  <= (cmd.space == bsf_pkg::SPACE_NVM);
            hold_q <= cmd.operand; // retired data once the wait is over
            cnt_q <= rem - 1'b1;
            if (dacc_now)
            begin
              res_valid <= 1'b1;
              res       <= '{data: cmd.operand, status_flags_register: status_flags_register_q};
            end
            else if (rem == '0)
              state_q <= ST_WAIT_NVM;
            else
              state_q <= ST_WAIT_CNT;
          end
        end
        ST_IO_RMW:
        begin
          res_valid <= 1'b1;
          res       <= '{data: io_mod, status_flags_register: status_flags_register_q};
          state_q   <= ST_IDLE;
        end
        ST_WAIT_CNT:
        begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == '0)
          begin
            state_q   <= nvm_q ? ST_WAIT_NVM : ST_IDLE;
            res_valid <= ~nvm_q;
            res       <= nvm_q ? res : '{data: hold_q, status_flags_register: status_flags_register_q};
          end
        end
        ST_WAIT_NVM:
        begin
          if (nvm_ready)
          begin
            res_valid <= 1'b1;
            res       <= '{data: hold_q, status_flags_register: status_flags_register_q};
            state_q   <= ST_IDLE;
          end
        end
        default:      state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  bsf_pkg::bsf_cmd_t prv_cmd_q;
  logic [7:0]        prv_status_flags_register_q;

  // copy of the last accepted instruction
  always_ff @(posedge clk)
  begin
    if (acc)
    begin
      prv_cmd_q  <= cmd;
      prv_status_flags_register_q <= status_flags_register_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_io_tail;
    (io_we && !cmd_ready && $stable(status_flags_register_q)) ##1 (res_valid && cmd_ready);
  endsequence
  sequence s_one_pulse(sig);
    sig ##1 !sig;
  endsequence

  property p_rotate_left;
    acc && cmd.op == bsf_pkg::OP_ROTATE_LEFT_VIA_CARRY |=> res_valid &&
      res.data == {prv_cmd_q.operand[6:0], prv_status_flags_register_q[0]} && status_flags_register_q[0] == prv_cmd_q.operand[7];
  endproperty
  a_rotate_left: assert property (p_rotate_left) else $error("rotate left wrong");

  property p_rotate_right;
    acc && cmd.op == bsf_pkg::OP_ROTATE_RIGHT_VIA_CARRY |=> res_valid &&
      res.data == {prv_status_flags_register_q[0], prv_cmd_q.operand[7:1]} && status_flags_register_q[0] == prv_cmd_q.operand[0]
      && status_flags_register_q[5] == prv_status_flags_register_q[5];
  endproperty
  a_rotate_right: assert property (p_rotate_right) else $error("rotate right wrong");

  property p_io_force;
    acc && is_io_op |=> s_io_tail;
  endproperty
  a_io_force: assert property (p_io_force) else $error("io bit op timing wrong");

  property p_io_value;
    io_we |-> io_wdata[io_bit_q] == io_one_q;
  endproperty
  a_io_value: assert property (p_io_value) else $error("io bit value wrong");

  property p_bit_to_t;
    acc && cmd.op == bsf_pkg::OP_BIT_TO_TRANSFER_FLAG |=>
      status_flags_register_q[6] == prv_cmd_q.operand[prv_cmd_q.bit_sel] &&
      (status_flags_register_q & 8'hbf) == (prv_status_flags_register_q & 8'hbf);
  endproperty
  a_bit_to_t: assert property (p_bit_to_t) else $error("transfer flag store wrong");

  property p_t_to_bit;
    acc && cmd.op == bsf_pkg::OP_TRANSFER_FLAG_TO_BIT |=>
      res.data[prv_cmd_q.bit_sel] == prv_status_flags_register_q[6] && status_flags_register_q == prv_status_flags_register_q;
  endproperty
  a_t_to_bit: assert property (p_t_to_bit) else $error("transfer flag load wrong");

  property p_overflow_raise;
    acc && cmd.op == bsf_pkg::OP_OVERFLOW_FLAG_RAISE |=> status_flags_register_q == (prv_status_flags_register_q | 8'h08);
  endproperty
  a_overflow_raise: assert property (p_overflow_raise) else $error("overflow raise wrong");

  property p_break;
    acc && cmd.op == bsf_pkg::OP_DEBUG_BREAK |=> s_one_pulse(debug_break) and
      ##0 $stable(status_flags_register_q);
  endproperty
  a_break: assert property (p_break) else $error("break pulse wrong");

  property p_low_io;
    acc && is_dacc && low_io && cmd.base_cycles == 4'h1 |=> !cmd_ready ##1 (cmd_ready && res_valid);
  endproperty
  a_low_io: assert property (p_low_io) else $error("low io extra cycle wrong");

  property p_nvm;
    acc && is_dacc && cmd.space == bsf_pkg::SPACE_NVM |=> !cmd_ready && !res_valid;
  endproperty
  a_nvm: assert property (p_nvm) else $error("nvm extra cycle missing");

  property p_swap;
    acc && cmd.op == bsf_pkg::OP_NIBBLE_EXCHANGE |=>
      res.data == {prv_cmd_q.operand[3:0], prv_cmd_q.operand[7:4]} && status_flags_register_q == prv_status_flags_register_q;
  endproperty
  a_swap: assert property (p_swap) else $error("nibble exchange wrong");

endmodule : bsf_unit

/* File: tb/bsf_tb.sv */
// self-checking bench for the bit, shift and flag unit
`timescale 1ns/100ps
module testbench;
  // ****************************************
  // stimulus and observation
  // ****************************************
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               cmd_valid = 1'b0;
  bsf_pkg::bsf_cmd_t  cmd = '0;
  logic               nvm_ready = 1'b1;
  logic [7:0]         io_rdata = 8'h5a;
  logic [1:0]         reg_addr = 2'h0;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_we = 1'b0;
  logic               reg_re = 1'b0;
  wire                cmd_ready, res_valid, io_re, io_we, debug_break, sleep_req, wdt_restart;
  wire [7:0]          io_addr, io_wdata, reg_rdata;
  bsf_pkg::bsf_res_t  res;
  int                 err_count = 0;
  int                 n_tests = 0;
  int                 cycles = 0;
  logic [7:0]         exp_s = 8'h00;
  logic [2:0]         fl [8] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6, 3'h5};

  bsf_unit dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .res_valid(res_valid), .res(res), .io_addr(io_addr), .io_re(io_re), .io_we(io_we),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .nvm_ready(nvm_ready),
    .debug_break(debug_break), .sleep_req(sleep_req), .wdt_restart(wdt_restart),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));

  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      conclude();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // issue one instruction, predict data, flags, strobes and retire latency
  task automatic exec(input bsf_pkg::bsf_op_t op, input logic [7:0] o = 8'h00,
                      input logic [2:0] bs = 3'h0, input int cyc = 1,
                      input logic [7:0] ia = 8'h00,
                      input bsf_pkg::bsf_space_t sp = bsf_pkg::SPACE_RAM,
                      input logic [3:0] bc = 4'h0);
    logic [7:0] r, s;
    logic       c, dchk, sh, io;
    int         n, k;
    r = o;
    s = exp_s;
    c = s[0];
    dchk = 1'b0;
    sh = 1'b1;
    io = (op == bsf_pkg::OP_IO_BIT_FORCE_ONE) || (op == bsf_pkg::OP_IO_BIT_FORCE_ZERO);
    k = int'(op) - int'(bsf_pkg::OP_CARRY_RAISE);
    case (op)
      bsf_pkg::OP_LOGICAL_SHIFT_UP:       begin r = {o[6:0], 1'b0}; c = o[7]; s[5] = o[3]; end
      bsf_pkg::OP_ROTATE_LEFT_VIA_CARRY:  begin r = {o[6:0], s[0]}; c = o[7]; s[5] = o[3]; end
      bsf_pkg::OP_LOGICAL_SHIFT_DOWN:     begin r = {1'b0, o[7:1]}; c = o[0]; end
      bsf_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin r = {s[0], o[7:1]}; c = o[0]; end
      bsf_pkg::OP_ARITHMETIC_SHIFT_DOWN:  begin r = {o[7], o[7:1]}; c = o[0]; end
      default:
      begin
        sh = 1'b0;
        dchk = 1'b1;
        case (op)
          bsf_pkg::OP_NIBBLE_EXCHANGE:      r = {o[3:0], o[7:4]};
          bsf_pkg::OP_IO_BIT_FORCE_ONE:     begin r = io_rdata; r[bs] = 1'b1; end
          bsf_pkg::OP_IO_BIT_FORCE_ZERO:    begin r = io_rdata; r[bs] = 1'b0; end
          bsf_pkg::OP_TRANSFER_FLAG_TO_BIT: r[bs] = s[6];
          bsf_pkg::OP_DATA_ACCESS:          r = o;
          bsf_pkg::OP_BIT_TO_TRANSFER_FLAG: begin s[6] = o[bs]; dchk = 1'b0; end
          bsf_pkg::OP_GENERIC_FLAG_RAISE:   begin s[bs] = 1'b1; dchk = 1'b0; end
          bsf_pkg::OP_GENERIC_FLAG_LOWER:   begin s[bs] = 1'b0; dchk = 1'b0; end
          default:
          begin
            dchk = 1'b0;
            if (k >= 0 && k < 16)
              s[fl[k/2]] = ~k[0];
          end
        endcase
      end
    endcase
    // shared flag results of every shift and rotate
    if (sh)
    begin
      s[0] = c;
      s[1] = (r == 8'h00);
      s[2] = r[7];
      s[3] = r[7] ^ c;
      s[4] = r[7] ^ r[7] ^ c;
      dchk = 1'b1;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, o, bs, ia, sp, bc};
    #1 chk("io_re", {7'h0, io}, {7'h0, io_re});
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 1;
    #1;
    if (io)
    begin
      chk("io_we", 8'h01, {7'h0, io_we});
      chk("io_addr", ia, io_addr);
      chk("io_wdata", r, io_wdata);
    end
    chk("pulses", {5'h0, op == bsf_pkg::OP_DEBUG_BREAK, op == bsf_pkg::OP_SLEEP_ENTER,
        op == bsf_pkg::OP_WATCHDOG_RESTART_INSTR}, {5'h0, debug_break, sleep_req, wdt_restart});
    while (res_valid !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (cyc > 0)
      chk("cycles", cyc[7:0], n[7:0]);
    else
      chk("long wait", 8'h01, {7'h0, n > -cyc});
    chk("status_flags_register", s, res.status_flags_register);
    if (dchk)
      chk("data", r, res.data);
    exp_s = s;
  endtask : exec

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
    if (a == bsf_pkg::REG_STATUS)
      exp_s = d;
  endtask : reg_wr

  task automatic reg_rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask : reg_rd

  // ****************************************
  // test sequence
  // ****************************************
  bsf_pkg::bsf_op_t shops [5] = '{bsf_pkg::OP_LOGICAL_SHIFT_UP, bsf_pkg::OP_LOGICAL_SHIFT_DOWN,
    bsf_pkg::OP_ROTATE_LEFT_VIA_CARRY, bsf_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
    bsf_pkg::OP_ARITHMETIC_SHIFT_DOWN};
  logic [7:0] vals [4] = '{8'h81, 8'h08, 8'h00, 8'h7e};

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reg_rd(bsf_pkg::REG_STATUS, 8'h00);
    // shifts and rotates with carry both ways
    for (int i = 0; i < 5; i++)
      for (int j = 0; j < 4; j++)
      begin
        exec(j[0] ? bsf_pkg::OP_CARRY_RAISE : bsf_pkg::OP_CARRY_LOWER);
        exec(shops[i], vals[j]);
      end
    exec(bsf_pkg::OP_HALF_CARRY_RAISE);
    exec(bsf_pkg::OP_ROTATE_RIGHT_VIA_CARRY, 8'h01);
    exec(bsf_pkg::OP_NIBBLE_EXCHANGE, 8'h3c);
    // io bit read-modify-write with all flags up
    reg_wr(bsf_pkg::REG_STATUS, 8'hff);
    exec(bsf_pkg::OP_IO_BIT_FORCE_ONE, 8'h00, 3'h0, 2, 8'h1f);
    exec(bsf_pkg::OP_IO_BIT_FORCE_ZERO, 8'h00, 3'h6, 2, 8'h3f);
    // transfer flag in and out
    reg_wr(bsf_pkg::REG_STATUS, 8'h00);
    exec(bsf_pkg::OP_BIT_TO_TRANSFER_FLAG, 8'h10, 3'h4);
    exec(bsf_pkg::OP_TRANSFER_FLAG_TO_BIT, 8'h00, 3'h2);
    exec(bsf_pkg::OP_BIT_TO_TRANSFER_FLAG, 8'hef, 3'h4);
    exec(bsf_pkg::OP_TRANSFER_FLAG_TO_BIT, 8'hff, 3'h7);
    // generic and dedicated flag operations
    for (int i = 0; i < 8; i++)
      exec(bsf_pkg::OP_GENERIC_FLAG_RAISE, 8'h00, i[2:0]);
    for (int i = 0; i < 8; i++)
      exec(bsf_pkg::OP_GENERIC_FLAG_LOWER, 8'h00, i[2:0]);
    for (int k = 0; k < 16; k++)
      exec(bsf_pkg::bsf_op_t'(int'(bsf_pkg::OP_CARRY_RAISE) + k));
    // core control pulses leave flags alone
    reg_wr(bsf_pkg::REG_STATUS, 8'h5a);
    exec(bsf_pkg::OP_DEBUG_BREAK);
    exec(bsf_pkg::OP_SLEEP_ENTER);
    exec(bsf_pkg::OP_WATCHDOG_RESTART_INSTR);
    // data access timing by space and address
    exec(bsf_pkg::OP_DATA_ACCESS, 8'h11, 3'h0, 2, 8'h00, bsf_pkg::SPACE_RAM, 4'h2);
    exec(bsf_pkg::OP_DATA_ACCESS, 8'h12, 3'h0, 2, 8'h3f, bsf_pkg::SPACE_IO, 4'h1);
    exec(bsf_pkg::OP_DATA_ACCESS, 8'h13, 3'h0, 1, 8'h40, bsf_pkg::SPACE_IO, 4'h1);
    exec(bsf_pkg::OP_DATA_ACCESS, 8'h14, 3'h0, 2, 8'h00, bsf_pkg::SPACE_NVM, 4'h1);
    @(posedge clk) nvm_ready <= 1'b0;
    fork
      begin
        repeat (6) @(posedge clk);
        nvm_ready <= 1'b1;
      end
    join_none
    exec(bsf_pkg::OP_DATA_ACCESS, 8'h33, 3'h0, -3, 8'h00, bsf_pkg::SPACE_NVM, 4'h1);
    // software port: status rw, others read only, unmapped reads zero
    reg_wr(bsf_pkg::REG_STATUS, 8'ha5);
    reg_rd(bsf_pkg::REG_STATUS, 8'ha5);
    reg_wr(bsf_pkg::REG_RESULT, 8'h00);
    reg_rd(bsf_pkg::REG_RESULT, 8'h33);
    reg_rd(bsf_pkg::REG_STATE, 8'h00);
    reg_rd(2'h3, 8'h00);
    conclude();
  end
endmodule : testbench
